// File: common/msq_pkg.sv
// constants and types shared by the conversion sequencer
package msq_pkg;

  // configuration word, first bit shifted in lands in single_ended
  typedef struct packed {
    logic       single_ended;
    logic       odd_sign;
    logic [1:0] select;
    logic       unipolar;
    logic       gain;
    logic       nap;
    logic       sleep;
  } msq_cfg_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_LOAD    = 2'b10
  } msq_state_type;

  // word framing on the serial link
  localparam logic [3:0] CFG_BITS    = 4'h8;
  localparam logic [3:0] ACQ_BIT     = 4'h6;
  localparam logic [3:0] NAP_END_BIT = 4'h2;

  // result format; a 12 or 14 bit variant leaves the low bits zero
  localparam int          RESULT_BITS  = 16;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [2:0]  COM_CHANNEL  = 3'h0;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_CONV_NS     = 4000;
  localparam int T_ACQ_NS      = 4000;
  localparam int CONV_CYCLES   = (T_CONV_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int BIT_CYCLES    = CONV_CYCLES / RESULT_BITS;
  localparam logic [3:0] BIT_CNT_MAX = 4'(BIT_CYCLES - 1);

endpackage

// File: hdl/msq_sar_step.sv
// successive-approximation register, one decision per step pulse
`timescale 1ns/1ps
module msq_sar_step #(
  parameter int WIDTH = 16,
  parameter int RES   = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             comp_high,
  output logic      [WIDTH-1:0] trial_q,
  output logic      [WIDTH-1:0] result_q,
  output logic                  done_q
);

  localparam logic [WIDTH-1:0] MSB_MASK = {1'b1, {(WIDTH-1){1'b0}}};
  localparam logic [WIDTH-1:0] LSB_MASK = MSB_MASK >> (RES - 1);

  logic [WIDTH-1:0] trial_d;
  logic [WIDTH-1:0] result_d;
  logic [WIDTH-1:0] mask_q;
  logic [WIDTH-1:0] mask_d;
  logic             active_q;
  logic             active_d;
  logic             done_d;
  logic [WIDTH-1:0] kept;

  always_comb begin
    trial_d  = trial_q;
    result_d = result_q;
    mask_d   = mask_q;
    active_d = active_q;
    done_d   = 1'b0;
    // comparator low means the trial bit overshot the input
    kept     = comp_high ? trial_q : (trial_q & ~mask_q);
    if (start) begin
      trial_d  = MSB_MASK;
      mask_d   = MSB_MASK;
      active_d = 1'b1;
    end else if (step && active_q) begin
      if (mask_q == LSB_MASK) begin
        trial_d  = kept;
        result_d = kept;
        active_d = 1'b0;
        done_d   = 1'b1;
      end else begin
        mask_d  = mask_q >> 1;
        trial_d = kept | (mask_q >> 1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trial_q  <= '0;
      result_q <= '0;
      mask_q   <= '0;
      active_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      trial_q  <= trial_d;
      result_q <= result_d;
      mask_q   <= mask_d;
      active_q <= active_d;
      done_q   <= done_d;
    end
  end

endmodule

// File: hdl/msq_sequencer.sv
// conversion sequencer: serial config, acquisition, sar timing, readout
// What this block does
// - host shifts eight config bits; taken on first eight shift-clock rises
// - config word picks channel and span for next conversion, power-down for after it
// - acquisition opens on the shift-clock fall after the sixth bit
// - convert trigger rise ends acquisition and starts conversion together
// - trigger edges during a running conversion are ignored
// - sar decides bits one by one, msb first down to lsb
// - finished sar word loads into the output shift register
// - result is 16 bits wide, sent out serially
// - unipolar result is natural binary, one step is full scale over 65536
// - bipolar result is two's complement
// - bipolar top code is zero then ones; just below zero is all ones
// - four spans: 0-5 V, 0-10 V, +-5 V, +-10 V
// - single-ended or differential pair chosen per conversion
// - status output low while converting, high otherwise
// - serial input bits after the eighth ignored until next conversion completes
// - each result comes out on the transfer after its requesting word
// - fifth and sixth bits are unipolar select and span select
`timescale 1ns/1ps
module msq_sequencer (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        shift_clk,
  input  wire logic        serial_in,
  input  wire logic        convert_trigger,
  input  wire logic        comp_in,
  output logic             serial_out,
  output logic             conv_idle,
  output logic             acquire,
  output logic       [2:0] mux_pos_ch,
  output logic       [2:0] mux_neg_ch,
  output logic             single_ended_select,
  output logic             unipolar_select,
  output logic             span_10v,
  output logic             nap_active,
  output logic             sleep_select,
  output logic      [15:0] dac_code
);

  // every pin is asynchronous to ref_clk: two stages, third for edges
  logic [2:0] sck_q;
  logic [1:0] din_q;
  logic [2:0] trig_q;
  logic [1:0] comp_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q  <= 3'h0;
      din_q  <= 2'h0;
      trig_q <= 3'h0;
      comp_q <= 2'h0;
    end else begin
      sck_q  <= {sck_q[1:0], shift_clk};
      din_q  <= {din_q[0], serial_in};
      trig_q <= {trig_q[1:0], convert_trigger};
      comp_q <= {comp_q[0], comp_in};
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic trig_rise;
  assign sck_rise  = sck_q[1] & ~sck_q[2];
  assign sck_fall  = ~sck_q[1] & sck_q[2];
  assign trig_rise = trig_q[1] & ~trig_q[2];

  // control state
  msq_pkg::msq_state_type state_q;
  msq_pkg::msq_state_type state_d;
  msq_pkg::msq_cfg_type   cfg_rx_q;
  msq_pkg::msq_cfg_type   cfg_rx_d;
  msq_pkg::msq_cfg_type   cfg_act_q;
  msq_pkg::msq_cfg_type   cfg_act_d;
  logic [3:0]             bit_cnt_q;
  logic [3:0]             bit_cnt_d;
  logic [15:0]            out_shift_q;
  logic [15:0]            out_shift_d;
  logic [3:0]             div_q;
  logic [3:0]             div_d;
  logic                   acquire_q;
  logic                   acquire_d;
  logic                   conv_idle_q;
  logic                   conv_idle_d;
  logic                   nap_q;
  logic                   nap_d;
  logic                   sleep_q;
  logic                   sleep_d;
  logic [2:0]             pos_q;
  logic [2:0]             pos_d;
  logic [2:0]             neg_q;
  logic [2:0]             neg_d;
  logic                   sar_start;
  logic                   sar_step;
  logic [15:0]            sar_trial;
  logic [15:0]            sar_result;
  logic                   sar_done;
  logic [15:0]            coded;

  // conversion clock as an enable, only runs while converting
  assign sar_step = (state_q == msq_pkg::ST_CONVERT) &&
                    (div_q == msq_pkg::BIT_CNT_MAX);

  msq_sar_step #(
    .WIDTH (16),
    .RES   (msq_pkg::RESULT_BITS)
  ) u_sar (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .start     (sar_start),
    .step      (sar_step),
    .comp_high (comp_q[1]),
    .trial_q   (sar_trial),
    .result_q  (sar_result),
    .done_q    (sar_done)
  );

  // comparator works in offset binary; bipolar flips the msb
  assign coded = cfg_act_q.unipolar ? sar_result
               : {~sar_result[15], sar_result[14:0]};

  always_comb begin
    state_d     = state_q;
    cfg_rx_d    = cfg_rx_q;
    cfg_act_d   = cfg_act_q;
    bit_cnt_d   = bit_cnt_q;
    out_shift_d = out_shift_q;
    acquire_d   = acquire_q;
    nap_d       = nap_q;
    sleep_d     = sleep_q;
    sar_start   = 1'b0;
    div_d       = (state_q == msq_pkg::ST_CONVERT) ?
                  ((div_q == msq_pkg::BIT_CNT_MAX) ? 4'h0 : div_q + 4'h1)
                  : 4'h0;
    // config bits on the first eight rises only
    if (sck_rise && (bit_cnt_q < msq_pkg::CFG_BITS)) begin
      cfg_rx_d  = {cfg_rx_q[6:0], din_q[1]};
      bit_cnt_d = bit_cnt_q + 4'h1;
    end
    if (sck_fall) begin
      out_shift_d = {out_shift_q[14:0], 1'b0};
      if (bit_cnt_q == msq_pkg::ACQ_BIT &&
          state_q == msq_pkg::ST_IDLE) begin
        acquire_d = 1'b1;
        // mux and span steer early; power bits arrive later
        cfg_act_d = {cfg_rx_q[5:0], cfg_act_q.nap, cfg_act_q.sleep};
      end
      if (bit_cnt_q == msq_pkg::NAP_END_BIT) begin
        nap_d = 1'b0;
      end
    end
    case (state_q)
      msq_pkg::ST_IDLE: begin
        if (trig_rise) begin
          state_d   = msq_pkg::ST_CONVERT;
          acquire_d = 1'b0;
          cfg_act_d = cfg_rx_q;
          sar_start = 1'b1;
        end
      end
      msq_pkg::ST_CONVERT: begin
        // trigger not looked at here, so it cannot restart
        if (sar_done) begin
          state_d = msq_pkg::ST_LOAD;
        end
      end
      msq_pkg::ST_LOAD: begin
        state_d     = msq_pkg::ST_IDLE;
        out_shift_d = coded;
        bit_cnt_d   = 4'h0;
        nap_d       = cfg_act_q.nap & ~cfg_act_q.sleep;
        sleep_d     = cfg_act_q.sleep;
      end
      default: begin
        state_d = msq_pkg::ST_IDLE;
      end
    endcase
    conv_idle_d = (state_d == msq_pkg::ST_IDLE);
    // differential pairs are adjacent; odd bit swaps polarity
    pos_d = {cfg_act_d.select, cfg_act_d.odd_sign};
    neg_d = cfg_act_d.single_ended ? msq_pkg::COM_CHANNEL
          : {cfg_act_d.select, ~cfg_act_d.odd_sign};
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= msq_pkg::ST_IDLE;
      cfg_rx_q    <= msq_pkg::CFG_RESET;
      cfg_act_q   <= msq_pkg::CFG_RESET;
      bit_cnt_q   <= 4'h0;
      out_shift_q <= msq_pkg::RESULT_RESET;
      div_q       <= 4'h0;
      acquire_q   <= 1'b0;
      conv_idle_q <= 1'b1;
      nap_q       <= 1'b0;
      sleep_q     <= 1'b0;
      pos_q       <= 3'h0;
      neg_q       <= 3'h1;
    end else begin
      state_q     <= state_d;
      cfg_rx_q    <= cfg_rx_d;
      cfg_act_q   <= cfg_act_d;
      bit_cnt_q   <= bit_cnt_d;
      out_shift_q <= out_shift_d;
      div_q       <= div_d;
      acquire_q   <= acquire_d;
      conv_idle_q <= conv_idle_d;
      nap_q       <= nap_d;
      sleep_q     <= sleep_d;
      pos_q       <= pos_d;
      neg_q       <= neg_d;
    end
  end

  assign serial_out          = out_shift_q[15];
  assign conv_idle           = conv_idle_q;
  assign acquire             = acquire_q;
  assign mux_pos_ch          = pos_q;
  assign mux_neg_ch          = neg_q;
  assign single_ended_select = cfg_act_q.single_ended;
  assign unipolar_select     = cfg_act_q.unipolar;
  assign span_10v            = cfg_act_q.gain;
  assign nap_active          = nap_q;
  assign sleep_select        = sleep_q;
  assign dac_code            = sar_trial;

  // checks
  localparam int CONV_LO = 150;
  localparam int CONV_HI = 175;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  logic conv_start;
  assign conv_start = (state_q == msq_pkg::ST_IDLE) && trig_rise;

  sequence start_s;
    conv_start;
  endsequence

  sequence load_s;
    sar_done ##1 (state_q == msq_pkg::ST_LOAD);
  endsequence

  status_low_a: assert property (
    start_s |=> (!conv_idle_q)[*8])
    else $error("status not low during conversion");

  status_high_a: assert property (
    load_s |=> conv_idle_q && (state_q == msq_pkg::ST_IDLE))
    else $error("status not released after load");

  conv_time_a: assert property (
    start_s |-> ##[CONV_LO:CONV_HI] sar_done)
    else $error("conversion length out of range");

  no_restart_a: assert property (
    (state_q == msq_pkg::ST_CONVERT) && trig_rise |=>
      $stable(cfg_act_q) && !sar_start)
    else $error("trigger restarted a conversion");

  sar_msb_a: assert property (
    start_s |=> (sar_trial == 16'h8000) ##10
      (sar_trial[14] == 1'b1))
    else $error("sar did not begin at msb");

  result_load_a: assert property (
    load_s |=> out_shift_q == (cfg_act_q.unipolar ? sar_result
                 : {~sar_result[15], sar_result[14:0]}))
    else $error("result not loaded into output register");

  bit_limit_a: assert property (
    sck_rise && (bit_cnt_q == msq_pkg::CFG_BITS) &&
      (state_q != msq_pkg::ST_LOAD) |=>
      $stable(cfg_rx_q) && (bit_cnt_q == msq_pkg::CFG_BITS))
    else $error("bits past the eighth were taken");

  acq_open_a: assert property (
    sck_fall && (bit_cnt_q == msq_pkg::ACQ_BIT) && !trig_rise &&
      (state_q == msq_pkg::ST_IDLE) |=> acquire_q)
    else $error("acquisition did not open");

  acq_close_a: assert property (
    start_s |=> !acquire_q && (cfg_act_q == $past(cfg_rx_q)))
    else $error("conversion start did not end acquisition");

  cfg_bit_a: assert property (
    sck_rise && (bit_cnt_q < msq_pkg::CFG_BITS) &&
      (state_q != msq_pkg::ST_LOAD) |=>
      (cfg_rx_q[0] == $past(din_q[1])) &&
      (bit_cnt_q == $past(bit_cnt_q) + 4'h1))
    else $error("config bit not captured");

  shift_out_a: assert property (
    sck_fall && (state_q != msq_pkg::ST_LOAD) |=>
      out_shift_q == {$past(out_shift_q[14:0]), 1'b0})
    else $error("result register did not shift");

  mux_pair_a: assert property (
    !single_ended_select |-> (mux_pos_ch[2:1] == mux_neg_ch[2:1]) &&
      (mux_pos_ch[0] != mux_neg_ch[0]))
    else $error("differential pair not adjacent");

endmodule

// File: verif/msq_host_model.sv
// host side model: three-wire link frames and the convert trigger
`timescale 1ns/1ps
module msq_host_model (
  input  wire logic ref_clk,
  input  wire logic serial_out,
  output logic      shift_clk,
  output logic      serial_in,
  output logic      convert_trigger
);
  initial begin
    shift_clk       = 1'b0;
    serial_in       = 1'b1;
    convert_trigger = 1'b0;
  end

  // one full-duplex frame: 8 config bits out, 16 result bits in, msb first
  // clock stands low between frames; high 3, low 5 ref_clk = 200 ns
  task automatic xfer(input logic [7:0] cfg, output logic [15:0] rx);
    @(negedge ref_clk);
    serial_in = cfg[7];
    for (int i = 0; i < 16; i++) begin
      repeat (5) @(negedge ref_clk);
      rx[15-i]  = serial_out;
      shift_clk = 1'b1;
      repeat (3) @(negedge ref_clk);
      shift_clk = 1'b0;
      // new bit on the fall; past the word it toggles to expose sampling
      serial_in = (i < 7) ? cfg[6-i] : ~serial_in;
    end
  endtask

  // settle cycles give the sampling capacitors time before the edge
  task automatic trigger(input int settle);
    repeat (settle) @(negedge ref_clk);
    convert_trigger = 1'b1;
    repeat (4) @(negedge ref_clk);
    convert_trigger = 1'b0;
  endtask
endmodule

// File: verif/msq_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module msq_sequencer_tb;
  localparam int ACQ_CYC = msq_pkg::T_ACQ_NS / msq_pkg::CLK_PERIOD_NS;

  logic        ref_clk;
  logic        reset_n;
  logic        shift_clk;
  logic        serial_in;
  logic        convert_trigger;
  logic        comp_in;
  logic        serial_out;
  logic        conv_idle;
  logic        acquire;
  logic [2:0]  mux_pos_ch;
  logic [2:0]  mux_neg_ch;
  logic        single_ended_select;
  logic        unipolar_select;
  logic        span_10v;
  logic        nap_active;
  logic        sleep_select;
  logic [15:0] dac_code;
  logic [15:0] level;
  int          fail_count;
  int          comparisons;
  logic [7:0]  cfgs [5] = '{8'hF8, 8'h20, 8'h54, 8'h8D, 8'h7E};
  logic [15:0] lvls [5] = '{16'h1234, 16'hFFFF, 16'h7FFF, 16'h0001, 16'hA5C3};

  // ideal comparator: input at or above the trial code keeps the bit
  always @(negedge ref_clk) comp_in <= (level >= dac_code);

  msq_host_model host (
    .ref_clk         (ref_clk),
    .serial_out      (serial_out),
    .shift_clk       (shift_clk),
    .serial_in       (serial_in),
    .convert_trigger (convert_trigger)
  );

  msq_sequencer uut (
    .ref_clk             (ref_clk),
    .reset_n             (reset_n),
    .shift_clk           (shift_clk),
    .serial_in           (serial_in),
    .convert_trigger     (convert_trigger),
    .comp_in             (comp_in),
    .serial_out          (serial_out),
    .conv_idle           (conv_idle),
    .acquire             (acquire),
    .mux_pos_ch          (mux_pos_ch),
    .mux_neg_ch          (mux_neg_ch),
    .single_ended_select (single_ended_select),
    .unipolar_select     (unipolar_select),
    .span_10v            (span_10v),
    .nap_active          (nap_active),
    .sleep_select        (sleep_select),
    .dac_code            (dac_code)
  );

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_mux(input logic [7:0] c);
    check(16'(mux_pos_ch), 16'({c[5:4], c[6]}));
    check(16'(mux_neg_ch), 16'(c[7] ? 3'h0 : {c[5:4], ~c[6]}));
    check(16'(single_ended_select), 16'(c[7]));
    check(16'(unipolar_select), 16'(c[3]));
    check(16'(span_10v), 16'(c[2]));
  endtask

  // follows the frame fall by fall; nap must end at the second fall
  task automatic mid_checks(input logic [7:0] c, input logic nap);
    int n;
    for (int f = 1; f <= 6; f++) begin
      n = 0;
      while (shift_clk !== 1'b1 && n < 20) begin
        @(negedge ref_clk);
        n++;
      end
      while (shift_clk !== 1'b0 && n < 20) begin
        @(negedge ref_clk);
        n++;
      end
      if (n >= 20) fail_count++;
      repeat (5) @(negedge ref_clk);
      if (nap && f <= 2) check(16'(nap_active), 16'(f == 1));
      if (f == 5) check(16'(acquire), 16'h0000);
    end
    check(16'(acquire), 16'h0001);
    check_mux(c);
  endtask

  task automatic run_conv(input logic retrig);
    int n;
    host.trigger(ACQ_CYC);
    n = 0;
    while (conv_idle !== 1'b0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(conv_idle), 16'h0000);
    check(16'(acquire), 16'h0000);
    check(dac_code, 16'h8000);
    repeat (15) @(negedge ref_clk);
    check(dac_code, {level[15], 15'h4000});
    // a second edge mid-conversion must neither restart nor queue
    if (retrig) host.trigger(10);
    n = 0;
    while (conv_idle !== 1'b1 && n < 170) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(conv_idle), 16'h0001);
    repeat (20) @(negedge ref_clk);
    check(16'(conv_idle), 16'h0001);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    logic [15:0] rx;
    logic [15:0] exp_prev;
    logic [7:0]  c;
    fail_count  = 0;
    comparisons = 0;
    reset_n     = 1'b0;
    level       = 16'h0000;
    exp_prev    = msq_pkg::RESULT_RESET;
    repeat (6) @(negedge ref_clk);
    check(16'(conv_idle), 16'h0001);
    check(16'(acquire), 16'h0000);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int k = 0; k <= 5; k++) begin
      c = (k < 5) ? cfgs[k] : 8'h00;
      fork
        host.xfer(c, rx);
        mid_checks(c, k == 5);
      join
      check(rx, exp_prev);
      check_mux(c);
      if (k == 5) break;
      level = lvls[k];
      run_conv(k == 1);
      // bipolar: two's complement, i.e. offset code with msb inverted
      exp_prev = c[3] ? level : level ^ 16'h8000;
      if (k == 3) check(16'(sleep_select), 16'h0001);
      if (k == 4) check(16'(nap_active), 16'h0001);
    end
    stop_test();
  end
endmodule
